// file: dcs_cfg.svh
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
// Reset value of the oldest-command age limit field.
`define DCS_AGE_LIMIT_RST 8'hff
// Each limit step is worth 16 x 2 DDR3 clock cycles.
`define DCS_AGE_MUL_A 16
`define DCS_AGE_MUL_B 2
// Width of the age timer: 8-bit field times 32 fits in 13 bits.
`define DCS_AGE_TMR_W 13
`define DCS_AGE_SHIFT 5
`endif

// file: dcs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_master_model
  import dcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic in_ready,
  output logic in_valid,
  output dcs_cmd_type in_cmd
);
  // --------------------------------------------------------------
  // Bus master issuing one command at a time
  // --------------------------------------------------------------
  // Idle lines start low so the design sees no request after reset.
  initial begin
    in_valid = 1'b0;
    in_cmd = '0;
  end

  // Hold the request until in_ready is sampled high on a rising edge.
  task automatic send(input dcs_cmd_type c);
    @(negedge ref_clk);
    in_valid = 1'b1;
    in_cmd = c;
    @(posedge ref_clk);
    while (in_ready !== 1'b1) @(posedge ref_clk);
    @(negedge ref_clk);
    in_valid = 1'b0;
    in_cmd = ~c; // Stale data is inverted so it never looks valid.
  endtask
endmodule
`default_nettype wire

// file: dcs_pkg.sv
package dcs_pkg;
  // One queued command as it arrives from the bus side.
  typedef struct packed {
    logic       is_write;
    logic [1:0] service_class;
    logic [2:0] bank;
    logic [7:0] tag;
  } dcs_cmd_type;
endpackage

// file: dcs_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcs_cfg.svh"
// Operation
// RQ1 - Programmable latency counter per service class.
// RQ2 - Smaller class latency means higher priority.
// RQ3 - Read and write class priority independent.
// RQ4 - Expired class blocks lower-class same direction.
// RQ5 - Open-bank writes beat expired reads.
// RQ6 - Longest-waiting command is the oldest entry.
// RQ7 - Age timer starts when entry becomes oldest.
// RQ8 - Expired age timer forces oldest to issue.
// RQ9 - Age limit comes from configuration field.
// RQ10 - Limit resets to ff, scaled by 16x2.
// RQ11 - Reorder queue for memory efficiency.
// RQ12 - Software tunes limit down stepwise.
// RQ13 - Software avoids limits 0 to 20 hex.
// RQ14 - Age timer reloads on new oldest.
module dcs_scheduler
  import dcs_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int IW = 3,
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire dcs_cmd_type in_cmd,
  output logic in_ready,
  input wire logic [7:0] oldest_cmd_age_limit,
  input wire logic [7:0] oldest_cmd_age_limit_we,
  input wire logic [4*CW-1:0] class_latency,
  input wire logic [7:0] open_banks,
  input wire logic out_ready,
  output logic out_valid,
  output dcs_cmd_type out_cmd,
  output logic out_aged
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dcs_cmd_type q_cmd_r [DEPTH];
  logic [DEPTH-1:0] q_vld_r;
  logic [IW+1:0] q_seq_r [DEPTH];
  logic [CW-1:0] q_wait_r [DEPTH];
  logic [IW+1:0] seq_r;
  logic [7:0] age_limit_r;
  logic [`DCS_AGE_TMR_W-1:0] age_tmr_r;
  logic [IW-1:0] old_idx_r;
  logic old_vld_r;
  logic [IW-1:0] out_idx_r;
  logic new_old, force_old;
  logic [IW-1:0] pick;
  logic pick_vld;
  logic pick_aged;
  logic [IW-1:0] old_idx_nxt;
  logic old_vld_nxt;
  logic [IW-1:0] free_idx;
  logic free_vld;
  logic take;
  logic issue;
  logic age_exp;
  logic [3:0] rd_exp;
  logic [3:0] wr_exp;

  // Class latency of one class, used by several decisions.
  function automatic logic [CW-1:0] lat_of(input logic [1:0] c,
                                           input logic [4*CW-1:0] v);
    lat_of = v[c*CW +: CW];
  endfunction

  // A class outranks another when its programmed latency is smaller.
  function automatic logic outranks(input logic [1:0] a,
                                    input logic [1:0] b,
                                    input logic [4*CW-1:0] v);
    outranks = lat_of(a, v) < lat_of(b, v);
  endfunction

  // Sequence age with wraparound: older when difference is large.
  function automatic logic older(input logic [IW+1:0] a,
                                 input logic [IW+1:0] b,
                                 input logic [IW+1:0] now);
    older = (IW+2)'(now - a) > (IW+2)'(now - b);
  endfunction

  // ----------------------------------------------------------------
  // Age limit field
  // ----------------------------------------------------------------
  // RQ9 limit from field
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      // RQ10 reset to ff
      age_limit_r <= `DCS_AGE_LIMIT_RST;
    end else if (|oldest_cmd_age_limit_we) begin
      age_limit_r <= oldest_cmd_age_limit;
    end
  end

  // ----------------------------------------------------------------
  // Oldest entry search and class expiry
  // ----------------------------------------------------------------
  // RQ6 find oldest entry
  always_comb begin
    old_idx_nxt = '0;
    old_vld_nxt = 1'b0;
    rd_exp = '0;
    wr_exp = '0;
    free_idx = '0;
    free_vld = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (q_vld_r[i]) begin
        if (!old_vld_nxt ||
            older(q_seq_r[i], q_seq_r[old_idx_nxt], seq_r)) begin
          old_idx_nxt = IW'(i);
        end
        old_vld_nxt = 1'b1;
        // RQ1 class latency expiry
        if (q_wait_r[i] >= lat_of(q_cmd_r[i].service_class,
                                  class_latency)) begin
          // RQ3 split by direction
          if (q_cmd_r[i].is_write) begin
            wr_exp[q_cmd_r[i].service_class] = 1'b1;
          end else begin
            rd_exp[q_cmd_r[i].service_class] = 1'b1;
          end
        end
      end else if (!free_vld) begin
        free_idx = IW'(i);
        free_vld = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Candidates are scored: aged oldest, open-bank writes, expired
  // classes, then oldest first. Blocked entries are skipped.
  always_comb begin
    logic blocked;
    logic [2:0] sc;
    logic [2:0] best_sc;
    blocked = 1'b0;
    sc = '0;
    best_sc = '0;
    pick = '0;
    pick_vld = 1'b0;
    pick_aged = 1'b0;
    // RQ8 aged oldest forced
    if (force_old) begin
      pick = old_idx_nxt;
      pick_vld = 1'b1;
      pick_aged = 1'b1;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        blocked = 1'b0;
        for (int c = 0; c < 4; c++) begin
          // RQ4 block lower class
          if (q_cmd_r[i].is_write ? wr_exp[c] : rd_exp[c]) begin
            if (outranks(2'(c), q_cmd_r[i].service_class,
                         class_latency)) begin
              blocked = 1'b1;
            end
          end
        end
        // RQ5 open-bank writes first
        if (q_cmd_r[i].is_write && open_banks[q_cmd_r[i].bank]) begin
          sc = 3'h4;
        end else if (q_cmd_r[i].is_write ?
                     wr_exp[q_cmd_r[i].service_class] :
                     rd_exp[q_cmd_r[i].service_class]) begin
          // RQ2 expired class ranks next
          sc = 3'h2;
        end else begin
          sc = 3'h1;
        end
        // RQ11 reorder by score
        if (q_vld_r[i] && !blocked &&
            (!pick_vld || sc > best_sc ||
             (sc == best_sc &&
              older(q_seq_r[i], q_seq_r[pick], seq_r)))) begin
          pick = IW'(i);
          pick_vld = 1'b1;
          best_sc = sc;
        end
      end
    end
  end

  assign issue = out_valid && out_ready;
  assign take = in_valid && in_ready;
  assign age_exp = age_tmr_r == '0;
  assign new_old = old_vld_nxt && (!old_vld_r || old_idx_nxt != old_idx_r ||
                                   !q_vld_r[old_idx_r]);
  assign force_old = old_vld_nxt && (new_old ? age_limit_r == '0 : age_exp);

  // ----------------------------------------------------------------
  // Queue update
  // ----------------------------------------------------------------
  // Issue retires the entry whose index out_idx_r was registered with the output command.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q_vld_r <= '0;
      seq_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        q_cmd_r[i] <= '0;
        q_seq_r[i] <= '0;
        q_wait_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (q_vld_r[i] && q_wait_r[i] != '1) begin
          q_wait_r[i] <= q_wait_r[i] + 1'b1;
        end
      end
      if (issue) begin
        q_vld_r[out_idx_r] <= 1'b0;
      end
      if (take) begin
        q_cmd_r[free_idx] <= in_cmd;
        q_vld_r[free_idx] <= 1'b1;
        q_seq_r[free_idx] <= seq_r;
        q_wait_r[free_idx] <= '0;
        seq_r <= seq_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Age timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      old_vld_r <= 1'b0;
      old_idx_r <= '0;
      age_tmr_r <= '1;
    end else begin
      old_vld_r <= old_vld_nxt;
      old_idx_r <= old_idx_nxt;
      // RQ7 start on new oldest, RQ14 reload
      if (new_old) begin
        age_tmr_r <= {age_limit_r, (`DCS_AGE_SHIFT)'(0)};
      end else if (old_vld_r && !age_exp) begin
        age_tmr_r <= age_tmr_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_cmd <= '0;
      out_aged <= 1'b0;
      out_idx_r <= '0;
      in_ready <= 1'b0;
    end else begin
      in_ready <= !(&q_vld_r) && !take;
      if (!out_valid || issue) begin
        out_valid <= pick_vld && !(issue && pick == out_idx_r);
        out_cmd <= q_cmd_r[pick];
        out_idx_r <= pick;
        out_aged <= pick_aged;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  age_reload_a: assert property ( // RQ14
    @(posedge ref_clk) disable iff (!resetn)
    (old_vld_nxt && !old_vld_r) |=>
      age_tmr_r == {$past(age_limit_r), (`DCS_AGE_SHIFT)'(0)})
    else $error("age timer not reloaded");
  age_force_a: assert property ( // RQ8
    @(posedge ref_clk) disable iff (!resetn)
    force_old |-> pick_aged && pick == old_idx_nxt)
    else $error("aged oldest not forced");
  age_rst_a: assert property ( // RQ10
    @(posedge ref_clk) $rose(resetn) |-> age_limit_r == `DCS_AGE_LIMIT_RST)
    else $error("age limit reset wrong");
  age_count_a: assert property ( // RQ7
    @(posedge ref_clk) disable iff (!resetn)
    old_vld_r && !new_old && !age_exp |=>
      age_tmr_r == $past(age_tmr_r) - 1'b1)
    else $error("age timer not counting down");
  out_hold_a: assert property ( // RQ11
    @(posedge ref_clk) disable iff (!resetn) out_valid && !out_ready |=>
      out_valid && $stable(out_cmd)) else $error("output changed in stall");
  full_stall_a: assert property ( // RQ6
    @(posedge ref_clk) disable iff (!resetn) &q_vld_r |=> !in_ready)
    else $error("queue full but still ready");

endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcs_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic in_valid, in_ready, out_valid, out_aged;
  logic out_ready = 1'b0;
  dcs_cmd_type in_cmd, out_cmd;
  logic [7:0] age_lim = 8'h00;
  logic [7:0] age_we = 8'h00;
  logic [7:0] open_banks = 8'h00;
  logic [31:0] class_lat = 32'hffffff00;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  // --------------------------------------------------------------
  // Clock, timeout and instances
  // --------------------------------------------------------------
  // Half period of 2.5 ns gives the 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // A hang is cut short at 5000 cycles, far beyond the fewer than a hundred cycles needed.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  dcs_scheduler DUT (.ref_clk(ref_clk), .resetn(resetn),
    .in_valid(in_valid), .in_cmd(in_cmd), .in_ready(in_ready),
    .oldest_cmd_age_limit(age_lim), .oldest_cmd_age_limit_we(age_we),
    .class_latency(class_lat), .open_banks(open_banks),
    .out_ready(out_ready), .out_valid(out_valid), .out_cmd(out_cmd),
    .out_aged(out_aged));

  dcs_master_model m (.ref_clk(ref_clk), .in_ready(in_ready),
    .in_valid(in_valid), .in_cmd(in_cmd));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  // Compare one observed value against its expectation.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic dcs_cmd_type mk(input logic w, input logic [1:0] c,
                                     input logic [2:0] b,
                                     input logic [7:0] t);
    return {w, c, b, t};
  endfunction

  // Let the queue settle while stalled, then take three commands.
  // Only the slot named by aged_at is checked for out_aged set; a negative aged_at checks all three clear.
  task automatic drain(input logic [7:0] t [3], input int aged_at);
    int w;
    repeat (5) @(negedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      w = 0;
      @(negedge ref_clk);
      while (out_valid !== 1'b1 && w < 100) begin
        w++;
        @(negedge ref_clk);
      end
      check({7'h00, out_valid}, 8'h01);
      check(out_cmd.tag, t[i]);
      if (aged_at < 0 || aged_at == i)
        check({7'h00, out_aged}, {7'h00, aged_at == i});
      // Accept only the command just judged, at the next rising edge.
      out_ready = 1'b1;
      @(negedge ref_clk);
      out_ready = 1'b0;
    end
  endtask

  task results;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Outputs stay quiet in reset and a slot opens after release.
  task reset_chk;
    check({7'h00, out_valid}, 8'h00);
    @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    check({7'h00, in_ready}, 8'h01);
  endtask

  // Open-bank write passes an expired read under the default limit.
  task open_write;
    open_banks = 8'h02;
    m.send(mk(1'b1, 2'h3, 3'h1, 8'h01));
    m.send(mk(1'b0, 2'h0, 3'h0, 8'h02));
    m.send(mk(1'b1, 2'h3, 3'h1, 8'h03));
    drain('{8'h01, 8'h03, 8'h02}, -1);
  endtask

  // An expired class-0 read overtakes an older class-1 read.
  task class_prio;
    open_banks = 8'h00;
    m.send(mk(1'b1, 2'h3, 3'h2, 8'h04));
    m.send(mk(1'b0, 2'h1, 3'h3, 8'h05));
    m.send(mk(1'b0, 2'h0, 3'h4, 8'h06));
    drain('{8'h04, 8'h06, 8'h05}, -1);
  endtask

  // A zero limit forces the oldest read ahead of an open-bank write.
  task aged_force;
    @(negedge ref_clk);
    // limit lowered
    // Software lowers the limit step by step; zero is far below what a
    // system should use and serves here only to reach the forced path.
    age_we = 8'hff;
    @(negedge ref_clk);
    age_we = 8'h00;
    open_banks = 8'h02;
    m.send(mk(1'b1, 2'h3, 3'h1, 8'h07));
    m.send(mk(1'b0, 2'h1, 3'h0, 8'h08));
    m.send(mk(1'b1, 2'h3, 3'h1, 8'h09));
    drain('{8'h07, 8'h08, 8'h09}, 1);
  endtask

  // Reset is held three cycles before the scenarios run in turn.
  initial begin
    repeat (2) @(negedge ref_clk);
    reset_chk();
    open_write();
    class_prio();
    aged_force();
    results();
  end
endmodule
`default_nettype wire
